// File: hdl/psfu_map.svh
// Register map, field positions, reset values and timing figures of the status flag unit.
`ifndef PSFU_MAP_SVH
`define PSFU_MAP_SVH
`define PSFU_OFS_FLAGS      8'h00
`define PSFU_OFS_LATEST     8'h04
`define PSFU_OFS_FIRST      8'h08
`define PSFU_OFS_CTRL       8'h0C
`define PSFU_OFS_SCAN_SET   8'h10
`define PSFU_OFS_IRQ_STAT   8'h14
`define PSFU_OFS_IRQ_MASK   8'h18
`define PSFU_BIT_OPERR      0
`define PSFU_BIT_CARRY      1
`define PSFU_BIT_GT         2
`define PSFU_BIT_EQ         3
`define PSFU_BIT_LT         4
`define PSFU_BIT_AUX        5
`define PSFU_BIT_TOOL       6
`define PSFU_BIT_SCAN       7
`define PSFU_IRQ_OPERR      0
`define PSFU_IRQ_CARRY      1
`define PSFU_IRQ_AUX        2
`define PSFU_IRQ_TOOL       3
`define PSFU_IRQ_SCAN       4
`define PSFU_IRQ_W          5
`define PSFU_CTRL_SCAN_EN   0
`define PSFU_CTRL_CLR_FIRST 1
`define PSFU_FIRST_VALID    16
`define PSFU_ADDR_W         16
`define PSFU_AUX_W          32
`define PSFU_ZERO_ADDR      16'h0000
`define PSFU_ZERO_AUX       32'h0000_0000
`define PSFU_ZERO_WORD      32'h0000_0000
`define PSFU_ZERO_IRQ       5'h00
`define PSFU_RST_SCAN_SET   16'h0000
`define PSFU_SCAN_ONE       16'h0001
`define PSFU_SCAN_MAX       16'hFFFF
`define PSFU_AUX_ONE        32'h0000_0001
`define PSFU_RESP_OKAY      2'h0
`define PSFU_RESP_SLVERR    2'h2
`define PSFU_SCAN_UNIT_NS   1000000
`define PSFU_CLK_PERIOD_NS  40
`endif

// File: hdl/psfu_pkg.sv
// Types shared by the status flag unit.
`default_nettype none
package psfu_pkg;
  typedef enum logic [1:0] {
    AUX_IDLE,
    AUX_RUN,
    AUX_DONE
  } psfu_aux_state_t;
endpackage
`default_nettype wire

// File: hdl/psfu_flags.sv
// Special status flags of the controller execution engine, with an AXI4-Lite register slave.
// Summary of operation
// - Operation error flag pulses, never latches.
// - Each error stores its address as latest.
// - Latest error address overwritten on every error.
// - First error address kept, never overwritten; the code loads the next error's address after a first-error clear through CTRL.
// - Carry set on arithmetic overflow or underflow.
// - Shift instructions load carry with shifted bit.
// - Less-than flag on when first operand smaller.
// - Aux timer flag on at count zero.
// - Aux timer flag clears when trigger drops.
// - Tool port error sets communication error flag.
// - Scan longer than setting sets scan error.
// - Scan setting of zero sets scan error.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "psfu_map.svh"
module psfu_flags #(
  parameter int P_MS_CYCLES = `PSFU_SCAN_UNIT_NS / `PSFU_CLK_PERIOD_NS
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_op_error,
  input  wire logic [15:0] i_op_error_addr,
  input  wire logic        i_arith_valid,
  input  wire logic        i_arith_overflow,
  input  wire logic        i_arith_underflow,
  input  wire logic        i_shift_valid,
  input  wire logic        i_shift_out_bit,
  input  wire logic        i_cmp_valid,
  input  wire logic [15:0] i_cmp_first,
  input  wire logic [15:0] i_cmp_second,
  input  wire logic        i_aux_trigger,
  input  wire logic        i_aux_tick,
  input  wire logic [31:0] i_aux_set_value,
  input  wire logic        i_tool_comm_error,
  input  wire logic        i_scan_end,
  output logic             o_operation_error_pulse_flag,
  output logic             o_carry_flag,
  output logic             o_greater_than_flag,
  output logic             o_equal_flag,
  output logic             o_less_than_flag,
  output logic             o_aux_timer_done_flag,
  output logic             o_tool_port_comm_error_flag,
  output logic             o_constant_scan_error_flag,
  output logic             o_irq,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready
);

  function automatic logic psfu_mapped(input logic [7:0] addr);
    psfu_mapped = (addr == `PSFU_OFS_FLAGS) || (addr == `PSFU_OFS_LATEST) ||
                  (addr == `PSFU_OFS_FIRST) || (addr == `PSFU_OFS_CTRL) ||
                  (addr == `PSFU_OFS_SCAN_SET) || (addr == `PSFU_OFS_IRQ_STAT) ||
                  (addr == `PSFU_OFS_IRQ_MASK);
  endfunction

  logic [15:0]             latest_error_address;
  logic [15:0]             first_error_address;
  logic                    first_valid;
  logic                    scan_en;
  logic [15:0]             scan_set;
  logic [`PSFU_IRQ_W-1:0]  irq_stat;
  logic [`PSFU_IRQ_W-1:0]  irq_mask;
  logic [`PSFU_IRQ_W-1:0]  irq_evt;
  logic                    carry_set_evt;
  logic [7:0]              aw_addr;
  logic                    aw_held;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    w_held;
  logic                    wr_go;
  logic                    clr_first;
  logic                    rd_go;
  logic                    stat_rd;
  logic                    aux_trig_d;
  logic [31:0]             aux_count;
  psfu_pkg::psfu_aux_state_t aux_state;
  logic [31:0]             ms_cnt;
  logic [15:0]             scan_ms;
  logic                    scan_err_evt;

  // Operation error: one-cycle pulse, address capture.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_operation_error_pulse_flag <= 1'b0;
      latest_error_address         <= `PSFU_ZERO_ADDR;
    end else begin
      o_operation_error_pulse_flag <= i_op_error;
      if (i_op_error) begin
        latest_error_address <= i_op_error_addr;
      end
    end
  end

  // The first address survives until software clears it, so a burst of errors
  // cannot hide where the trouble started.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_error_address <= `PSFU_ZERO_ADDR;
      first_valid         <= 1'b0;
    end else if (i_op_error && (!first_valid || clr_first)) begin
      // An error in the same cycle as a clear is kept as the new first error.
      first_error_address <= i_op_error_addr;
      first_valid         <= 1'b1;
    end else if (clr_first) begin
      first_valid <= 1'b0;
    end
  end

  // Carry: arithmetic result takes priority over a shift in the same cycle.
  assign carry_set_evt = (i_arith_valid && (i_arith_overflow || i_arith_underflow)) ||
                         (!i_arith_valid && i_shift_valid && i_shift_out_bit);
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_carry_flag <= 1'b0;
    end else if (i_arith_valid) begin
      o_carry_flag <= i_arith_overflow || i_arith_underflow;
    end else if (i_shift_valid) begin
      o_carry_flag <= i_shift_out_bit;
    end
  end

  // Comparison flags are signed and always one-hot after a comparison.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_greater_than_flag <= 1'b0;
      o_equal_flag        <= 1'b0;
      o_less_than_flag    <= 1'b0;
    end else if (i_cmp_valid) begin
      o_greater_than_flag <= $signed(i_cmp_first) > $signed(i_cmp_second);
      o_equal_flag        <= i_cmp_first == i_cmp_second;
      o_less_than_flag    <= $signed(i_cmp_first) < $signed(i_cmp_second);
    end
  end

  // Auxiliary timer: loads on the trigger's rising edge, counts down on base ticks.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aux_trig_d            <= 1'b0;
      aux_count             <= `PSFU_ZERO_AUX;
      aux_state             <= psfu_pkg::AUX_IDLE;
      o_aux_timer_done_flag <= 1'b0;
    end else begin
      aux_trig_d <= i_aux_trigger;
      if (!i_aux_trigger) begin
        aux_state             <= psfu_pkg::AUX_IDLE;
        o_aux_timer_done_flag <= 1'b0;
      end else begin
        unique case (aux_state)
          psfu_pkg::AUX_IDLE: begin
            if (!aux_trig_d) begin
              aux_count <= i_aux_set_value;
              aux_state <= psfu_pkg::AUX_RUN;
            end
          end
          psfu_pkg::AUX_RUN: begin
            if (aux_count == `PSFU_ZERO_AUX) begin
              aux_state             <= psfu_pkg::AUX_DONE;
              o_aux_timer_done_flag <= 1'b1;
            end else if (i_aux_tick) begin
              aux_count <= aux_count - `PSFU_AUX_ONE;
            end
          end
          psfu_pkg::AUX_DONE: begin
            o_aux_timer_done_flag <= 1'b1;
          end
        endcase
      end
    end
  end

  // Tool port error is sticky; reading the flag word clears it, set winning.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tool_port_comm_error_flag <= 1'b0;
    end else if (i_tool_comm_error) begin
      o_tool_port_comm_error_flag <= 1'b1;
    end else if (rd_go && i_s_axi_araddr == `PSFU_OFS_FLAGS) begin
      o_tool_port_comm_error_flag <= 1'b0;
    end
  end

  // Scan timing in whole milliseconds; the counter saturates so a stalled scan cannot wrap.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ms_cnt  <= `PSFU_ZERO_WORD;
      scan_ms <= `PSFU_RST_SCAN_SET;
    end else if (i_scan_end) begin
      ms_cnt  <= `PSFU_ZERO_WORD;
      scan_ms <= `PSFU_RST_SCAN_SET;
    end else if (ms_cnt == 32'(P_MS_CYCLES - 1)) begin
      ms_cnt <= `PSFU_ZERO_WORD;
      if (scan_ms != `PSFU_SCAN_MAX) begin
        scan_ms <= scan_ms + `PSFU_SCAN_ONE;
      end
    end else begin
      ms_cnt <= ms_cnt + 32'h0000_0001;
    end
  end

  assign scan_err_evt = scan_en && ((scan_set == `PSFU_RST_SCAN_SET) || (scan_ms > scan_set));
  // The error holds until constant scan is switched off.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_constant_scan_error_flag <= 1'b0;
    end else if (scan_err_evt) begin
      o_constant_scan_error_flag <= 1'b1;
    end else if (!scan_en) begin
      o_constant_scan_error_flag <= 1'b0;
    end
  end

  // Interrupt status: sticky, cleared by reading it, a new event wins over the clear.
  always_comb begin
    irq_evt                  = `PSFU_ZERO_IRQ;
    irq_evt[`PSFU_IRQ_OPERR] = i_op_error;
    irq_evt[`PSFU_IRQ_CARRY] = carry_set_evt;
    irq_evt[`PSFU_IRQ_AUX]   = (aux_state == psfu_pkg::AUX_RUN) && i_aux_trigger &&
                               (aux_count == `PSFU_ZERO_AUX);
    irq_evt[`PSFU_IRQ_TOOL]  = i_tool_comm_error;
    irq_evt[`PSFU_IRQ_SCAN]  = scan_err_evt && !o_constant_scan_error_flag;
  end
  assign stat_rd = rd_go && (i_s_axi_araddr == `PSFU_OFS_IRQ_STAT);
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat <= `PSFU_ZERO_IRQ;
      o_irq    <= 1'b0;
    end else begin
      irq_stat <= (stat_rd ? `PSFU_ZERO_IRQ : irq_stat) | irq_evt;
      o_irq    <= |(((stat_rd ? `PSFU_ZERO_IRQ : irq_stat) | irq_evt) & irq_mask);
    end
  end

  // Write channel: address and data are taken independently, in either order.
  assign wr_go     = aw_held && w_held && !o_s_axi_bvalid;
  assign clr_first = wr_go && (aw_addr == `PSFU_OFS_CTRL) && w_strb[0] &&
                     w_data[`PSFU_CTRL_CLR_FIRST];
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held         <= 1'b0;
      aw_addr         <= 8'h00;
      w_held          <= 1'b0;
      w_data          <= `PSFU_ZERO_WORD;
      w_strb          <= 4'h0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= `PSFU_RESP_OKAY;
    end else begin
      if (o_s_axi_awready && i_s_axi_awvalid) begin
        aw_held         <= 1'b1;
        aw_addr         <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (o_s_axi_wready && i_s_axi_wvalid) begin
        w_held         <= 1'b1;
        w_data         <= i_s_axi_wdata;
        w_strb         <= i_s_axi_wstrb;
        o_s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= psfu_mapped(aw_addr) ? `PSFU_RESP_OKAY : `PSFU_RESP_SLVERR;
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid  <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scan_en  <= 1'b0;
      scan_set <= `PSFU_RST_SCAN_SET;
      irq_mask <= `PSFU_ZERO_IRQ;
    end else if (wr_go) begin
      if (aw_addr == `PSFU_OFS_CTRL && w_strb[0]) begin
        scan_en <= w_data[`PSFU_CTRL_SCAN_EN];
      end
      if (aw_addr == `PSFU_OFS_SCAN_SET) begin
        if (w_strb[0]) begin
          scan_set[7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          scan_set[15:8] <= w_data[15:8];
        end
      end
      if (aw_addr == `PSFU_OFS_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[`PSFU_IRQ_W-1:0];
      end
    end
  end

  // Read channel: one read at a time, data registered with the answer.
  assign rd_go = o_s_axi_arready && i_s_axi_arvalid;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= `PSFU_ZERO_WORD;
      o_s_axi_rresp   <= `PSFU_RESP_OKAY;
    end else if (rd_go) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rresp   <= psfu_mapped(i_s_axi_araddr) ? `PSFU_RESP_OKAY : `PSFU_RESP_SLVERR;
      o_s_axi_rdata   <= `PSFU_ZERO_WORD;
      unique case (i_s_axi_araddr)
        `PSFU_OFS_FLAGS: begin
          o_s_axi_rdata[`PSFU_BIT_OPERR] <= o_operation_error_pulse_flag;
          o_s_axi_rdata[`PSFU_BIT_CARRY] <= o_carry_flag;
          o_s_axi_rdata[`PSFU_BIT_GT]    <= o_greater_than_flag;
          o_s_axi_rdata[`PSFU_BIT_EQ]    <= o_equal_flag;
          o_s_axi_rdata[`PSFU_BIT_LT]    <= o_less_than_flag;
          o_s_axi_rdata[`PSFU_BIT_AUX]   <= o_aux_timer_done_flag;
          o_s_axi_rdata[`PSFU_BIT_TOOL]  <= o_tool_port_comm_error_flag;
          o_s_axi_rdata[`PSFU_BIT_SCAN]  <= o_constant_scan_error_flag;
        end
        `PSFU_OFS_LATEST:   o_s_axi_rdata[15:0] <= latest_error_address;
        `PSFU_OFS_FIRST: begin
          o_s_axi_rdata[15:0]               <= first_error_address;
          o_s_axi_rdata[`PSFU_FIRST_VALID]  <= first_valid;
        end
        `PSFU_OFS_CTRL:     o_s_axi_rdata[`PSFU_CTRL_SCAN_EN] <= scan_en;
        `PSFU_OFS_SCAN_SET: o_s_axi_rdata[15:0] <= scan_set;
        `PSFU_OFS_IRQ_STAT: o_s_axi_rdata[`PSFU_IRQ_W-1:0] <= irq_stat;
        `PSFU_OFS_IRQ_MASK: o_s_axi_rdata[`PSFU_IRQ_W-1:0] <= irq_mask;
        default:            o_s_axi_rdata <= `PSFU_ZERO_WORD;
      endcase
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  default clocking psfu_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  a_operr_pulse_once: assert property (
    o_operation_error_pulse_flag |-> $past(i_op_error))
    else $error("Operation error flag high without an error.");
  a_operr_not_held: assert property (
    !i_op_error |=> !o_operation_error_pulse_flag)
    else $error("Operation error flag held.");
  a_latest_addr_load: assert property (
    i_op_error |=> latest_error_address == $past(i_op_error_addr))
    else $error("Latest error address not updated.");
  a_first_addr_keep: assert property (
    first_valid && !clr_first |=> first_valid && $stable(first_error_address))
    else $error("First error address overwritten.");
  a_carry_arith: assert property (
    i_arith_valid && (i_arith_overflow || i_arith_underflow) |=> o_carry_flag)
    else $error("Carry not set on overflow or underflow.");
  a_carry_shift: assert property (
    !i_arith_valid && i_shift_valid |=> o_carry_flag == $past(i_shift_out_bit))
    else $error("Carry does not match shifted bit.");
  a_less_than_set: assert property (
    i_cmp_valid && ($signed(i_cmp_first) < $signed(i_cmp_second)) |=> o_less_than_flag)
    else $error("Less-than flag not set.");
  a_cmp_one_hot: assert property (
    i_cmp_valid |=> $onehot({o_greater_than_flag, o_equal_flag, o_less_than_flag}))
    else $error("Comparison flags not one-hot.");
  a_aux_done_zero: assert property (
    i_aux_trigger && aux_state == psfu_pkg::AUX_RUN && aux_count == `PSFU_ZERO_AUX
      |=> o_aux_timer_done_flag)
    else $error("Aux timer flag missing at zero.");
  a_aux_trig_off: assert property (
    !i_aux_trigger |=> !o_aux_timer_done_flag)
    else $error("Aux timer flag stayed after trigger off.");
  a_tool_err_set: assert property (
    i_tool_comm_error |=> o_tool_port_comm_error_flag [*2] or
      (o_tool_port_comm_error_flag ##1 !i_tool_comm_error))
    else $error("Tool port error flag not set.");
  a_scan_over: assert property (
    scan_en && scan_ms > scan_set |=> o_constant_scan_error_flag)
    else $error("Scan overrun not flagged.");
  a_scan_zero: assert property (
    scan_en && scan_set == `PSFU_RST_SCAN_SET |=> o_constant_scan_error_flag)
    else $error("Zero scan setting not flagged.");

endmodule
`default_nettype wire

// File: verification/psfu_flags_tb_top.sv
// Self-checking testbench of the status flag unit.
`timescale 1ns/1ps
`default_nettype none
`include "psfu_map.svh"
module psfu_flags_tb_top;
  localparam int P_MS = 4;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_op_error = 1'b0, i_arith_valid = 1'b0, i_arith_overflow = 1'b0, i_arith_underflow = 1'b0;
  logic        i_shift_valid = 1'b0, i_shift_out_bit = 1'b0, i_cmp_valid = 1'b0, i_aux_trigger = 1'b0;
  logic        i_aux_tick = 1'b0, i_tool_comm_error = 1'b0, i_scan_end = 1'b0;
  logic [15:0] i_op_error_addr = 16'h0000, i_cmp_first = 16'h0000, i_cmp_second = 16'h0000;
  logic [31:0] i_aux_set_value = 32'h0000_0000, i_s_axi_wdata = 32'h0000_0000;
  logic [7:0]  i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [3:0]  i_s_axi_wstrb = 4'hF;
  logic        i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic        i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  wire  [7:0]  flags;
  logic        o_irq, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  logic [31:0] o_s_axi_rdata;
  int          n_mismatch = 0;
  int          num_checks = 0;
  // Carry table columns: arith valid, overflow, underflow, shift valid, shifted bit, expected carry.
  logic [5:0]  carry_tab [6] = '{6'b110001, 6'b100000, 6'b101001, 6'b000100, 6'b000111, 6'b100110};
  logic [15:0] cmp_a [4] = '{16'hFFFF, 16'h0005, 16'h0007, 16'h8000};
  logic [15:0] cmp_b [4] = '{16'h0002, 16'h0005, 16'hFFFD, 16'h7FFF};
  logic [2:0]  cmp_e [4] = '{3'b001, 3'b010, 3'b100, 3'b001};

  psfu_flags #(.P_MS_CYCLES(P_MS)) DUT (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_op_error(i_op_error), .i_op_error_addr(i_op_error_addr),
    .i_arith_valid(i_arith_valid), .i_arith_overflow(i_arith_overflow), .i_arith_underflow(i_arith_underflow),
    .i_shift_valid(i_shift_valid), .i_shift_out_bit(i_shift_out_bit), .i_cmp_valid(i_cmp_valid),
    .i_cmp_first(i_cmp_first), .i_cmp_second(i_cmp_second), .i_aux_trigger(i_aux_trigger),
    .i_aux_tick(i_aux_tick), .i_aux_set_value(i_aux_set_value), .i_tool_comm_error(i_tool_comm_error),
    .i_scan_end(i_scan_end), .o_operation_error_pulse_flag(flags[0]), .o_carry_flag(flags[1]),
    .o_greater_than_flag(flags[2]), .o_equal_flag(flags[3]), .o_less_than_flag(flags[4]),
    .o_aux_timer_done_flag(flags[5]), .o_tool_port_comm_error_flag(flags[6]),
    .o_constant_scan_error_flag(flags[7]), .o_irq(o_irq), .i_s_axi_awaddr(i_s_axi_awaddr),
    .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
    .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
    .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
    .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
    .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
    .i_s_axi_rready(i_s_axi_rready)
  );

  always #20 i_clk_sys = ~i_clk_sys;

  task automatic cyc;
    @(posedge i_clk_sys);
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // The master never counts on a latency; a stuck handshake is cut off and counted.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    r = 2'h1;
    cyc;
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    while (k < 200) begin
      cyc;
      k++;
      if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      if (o_s_axi_bvalid === 1'b1) begin
        r = o_s_axi_bresp;
        i_s_axi_bready <= 1'b0;
        break;
      end
    end
    if (k >= 200) chk("write_timeout", 32'h0, 32'h1);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    d = 32'hDEAD_BEEF;
    r = 2'h1;
    cyc;
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    while (k < 200) begin
      cyc;
      k++;
      if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      if (o_s_axi_rvalid === 1'b1) begin
        d = o_s_axi_rdata;
        r = o_s_axi_rresp;
        i_s_axi_rready <= 1'b0;
        break;
      end
    end
    if (k >= 200) chk("read_timeout", 32'h0, 32'h1);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(nm, e, d);
    chk(nm, {30'h0, er}, {30'h0, r});
  endtask

  task automatic wait_bit(input string nm, input int b, input logic v, input int n);
    int k;
    k = 0;
    while (flags[b] !== v && k < n) begin
      cyc;
      #1;
      k++;
    end
    chk(nm, {31'h0, v}, {31'h0, flags[b]});
  endtask

  task automatic op_err(input logic [15:0] a);
    cyc;
    i_op_error <= 1'b1;
    i_op_error_addr <= a;
    cyc;
    i_op_error <= 1'b0;
    #1 chk("operr_on", 32'h1, {31'h0, flags[0]});
    cyc;
    #1 chk("operr_off", 32'h0, {31'h0, flags[0]});
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (5000) cyc;
    n_mismatch++;
    summarize;
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (5) cyc;
    i_rst_n <= 1'b1;
    rd_chk("flags_rst", `PSFU_OFS_FLAGS, `PSFU_ZERO_WORD, `PSFU_RESP_OKAY);
    rd_chk("scan_set_rst", `PSFU_OFS_SCAN_SET, {16'h0000, `PSFU_RST_SCAN_SET}, `PSFU_RESP_OKAY);
    rd_chk("first_rst", `PSFU_OFS_FIRST, `PSFU_ZERO_WORD, `PSFU_RESP_OKAY);
    rd_chk("unmapped_rd", 8'h1C, `PSFU_ZERO_WORD, `PSFU_RESP_SLVERR);
    axi_wr(8'h1C, 32'hFFFF_FFFF, r);
    chk("unmapped_wr", {30'h0, `PSFU_RESP_SLVERR}, {30'h0, r});
    // A masked event must not reach the interrupt line, an unmasked one must.
    axi_wr(`PSFU_OFS_IRQ_MASK, 32'h0000_0001, r);
    rd_chk("irq_mask", `PSFU_OFS_IRQ_MASK, 32'h0000_0001, `PSFU_RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      cyc;
      {i_arith_valid, i_arith_overflow, i_arith_underflow, i_shift_valid, i_shift_out_bit} <= carry_tab[i][5:1];
      cyc;
      {i_arith_valid, i_arith_overflow, i_arith_underflow, i_shift_valid, i_shift_out_bit} <= 5'h00;
      #1 chk("carry", {31'h0, carry_tab[i][0]}, {31'h0, flags[1]});
    end
    repeat (2) cyc;
    #1 chk("irq_masked", 32'h0, {31'h0, o_irq});
    op_err(16'h1234);
    cyc;
    #1 chk("irq_on", 32'h1, {31'h0, o_irq});
    rd_chk("irq_status", `PSFU_OFS_IRQ_STAT, 32'h0000_0003, `PSFU_RESP_OKAY);
    repeat (2) cyc;
    #1 chk("irq_cleared", 32'h0, {31'h0, o_irq});
    op_err(16'hBEEF);
    rd_chk("latest", `PSFU_OFS_LATEST, 32'h0000_BEEF, `PSFU_RESP_OKAY);
    rd_chk("first_kept", `PSFU_OFS_FIRST, 32'h0001_1234, `PSFU_RESP_OKAY);
    axi_wr(`PSFU_OFS_CTRL, 32'h0000_0002, r);
    op_err(16'h0042);
    rd_chk("first_new", `PSFU_OFS_FIRST, 32'h0001_0042, `PSFU_RESP_OKAY);
    rd_chk("latest_new", `PSFU_OFS_LATEST, 32'h0000_0042, `PSFU_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      cyc;
      i_cmp_valid <= 1'b1;
      i_cmp_first <= cmp_a[i];
      i_cmp_second <= cmp_b[i];
      cyc;
      i_cmp_valid <= 1'b0;
      #1 chk("compare", {29'h0, cmp_e[i]}, {29'h0, flags[2], flags[3], flags[4]});
    end
    // Two ticks of a set value of two must pass before the timer reports done.
    cyc;
    i_aux_set_value <= 32'h0000_0002;
    i_aux_trigger <= 1'b1;
    repeat (3) cyc;
    i_aux_tick <= 1'b1;
    cyc;
    i_aux_tick <= 1'b0;
    repeat (3) cyc;
    #1 chk("aux_early", 32'h0, {31'h0, flags[5]});
    cyc;
    i_aux_tick <= 1'b1;
    cyc;
    i_aux_tick <= 1'b0;
    wait_bit("aux_done", 5, 1'b1, 4);
    cyc;
    i_aux_trigger <= 1'b0;
    wait_bit("aux_release", 5, 1'b0, 3);
    cyc;
    i_tool_comm_error <= 1'b1;
    cyc;
    i_tool_comm_error <= 1'b0;
    #1 chk("tool_on", 32'h1, {31'h0, flags[6]});
    axi_rd(`PSFU_OFS_FLAGS, d, r);
    chk("flags_tool", 32'h1, {31'h0, d[6]});
    chk("flags_cmp", 32'h1, {29'h0, d[2], d[3], d[4]});
    repeat (2) cyc;
    #1 chk("tool_read_clear", 32'h0, {31'h0, flags[6]});
    axi_wr(`PSFU_OFS_CTRL, 32'h0000_0001, r);
    wait_bit("scan_zero_set", 7, 1'b1, 20);
    axi_wr(`PSFU_OFS_CTRL, 32'h0000_0000, r);
    wait_bit("scan_disabled", 7, 1'b0, 5);
    axi_wr(`PSFU_OFS_SCAN_SET, 32'h0000_0002, r);
    rd_chk("scan_set", `PSFU_OFS_SCAN_SET, 32'h0000_0002, `PSFU_RESP_OKAY);
    // Scan ends are held back-to-back while enabling, so no stale long scan is measured.
    cyc;
    i_scan_end <= 1'b1;
    axi_wr(`PSFU_OFS_CTRL, 32'h0000_0001, r);
    for (int i = 0; i < 4; i++) begin
      cyc;
      i_scan_end <= 1'b1;
      cyc;
      i_scan_end <= 1'b0;
      repeat (4) cyc;
      #1 chk("scan_short", 32'h0, {31'h0, flags[7]});
    end
    wait_bit("scan_long", 7, 1'b1, 20);
    #1 chk("irq_pending", 32'h1, {31'h0, o_irq});
    rd_chk("irq_status_all", `PSFU_OFS_IRQ_STAT, 32'h0000_001D, `PSFU_RESP_OKAY);
    summarize;
  end
endmodule
`default_nettype wire
